// >>> swk_host_model.sv
// Host side register master model driving the block's register port
`timescale 1ns/1ps
module swk_host_model (
  input  wire logic          clk_sys,
  input  wire logic [7:0]    rdata,
  output swk_pkg::swk_reg_req_t req
);
  initial req = '0;

  // ----------------------------------------------------------------
  // Access tasks: strobe held one cycle, released after the taking edge
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys) req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys) req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys) req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_sys) req <= '0;
    @(posedge clk_sys) #1;
    d = rdata;
  endtask
endmodule // swk_host_model

// >>> swk_pkg.sv
// Shared constants, register map and carrier types for the slider and wake block
package swk_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NSENS  = 6;   // Sensors on the slider
  localparam int DIFF_W = 12;  // Signed tick difference per sensor
  localparam int THR_W  = 10;  // Per-sensor touch threshold
  localparam int NEV    = 15;  // Wake event sources (12 buttons, touch, low, high)
  localparam int NKEY   = 6;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_HYST      = 8'h29;
  localparam logic [7:0] ADDR_STATUS    = 8'h2a;
  localparam logic [7:0] ADDR_SCALE_HI  = 8'h2b;
  localparam logic [7:0] ADDR_SCALE_LO  = 8'h2c;
  localparam logic [7:0] ADDR_AVG_THR   = 8'h2d;
  localparam logic [7:0] ADDR_NEG_THR   = 8'h2e;
  localparam logic [7:0] ADDR_NEG_CNT   = 8'h2f;
  localparam logic [7:0] ADDR_MOVE_THR  = 8'h30;
  localparam logic [7:0] ADDR_LOC_HI    = 8'h31;
  localparam logic [7:0] ADDR_LOC_LO    = 8'h32;
  localparam logic [7:0] ADDR_WAKE_LEN  = 8'h33;
  localparam logic [7:0] ADDR_KEYS_54   = 8'h34;
  localparam logic [7:0] ADDR_KEYS_32   = 8'h35;
  localparam logic [7:0] ADDR_KEYS_10   = 8'h36;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_HYST     = 8'h03;
  localparam logic [15:0] RST_SCALE    = 16'h0180;
  localparam logic [7:0]  RST_AVG_THR  = 8'h50;
  localparam logic [7:0]  RST_NEG_THR  = 8'h50;
  localparam logic [7:0]  RST_NEG_CNT  = 8'h01;
  localparam logic [7:0]  RST_MOVE_THR = 8'h02;
  localparam logic [2:0]  RST_WAKE_LEN = 3'h0;
  localparam logic [23:0] RST_KEYS     = 24'h000000;

  // ----------------------------------------------------------------
  // Field positions, scaling and codes
  // ----------------------------------------------------------------
  localparam int STAT_TOUCH_BIT  = 0;
  localparam int STAT_LOW_BIT    = 1;
  localparam int STAT_HIGH_BIT   = 2;
  localparam int STAT_HOLD_BIT   = 3;
  localparam int CODE_STEP_SHIFT = 2;   // Threshold codes count in steps of 4
  localparam int SCALE_SHIFT     = 5;   // Scale is divided by 32
  localparam int PERCENT_FULL    = 100;
  localparam logic [3:0] EV_SLIDER_TOUCH = 4'hc;
  localparam logic [3:0] EV_MOVE_LOW     = 4'hd;
  localparam logic [3:0] EV_MOVE_HIGH    = 4'he;
  localparam logic [2:0] WAKE_LEN_ANY    = 3'h0;
  localparam logic [2:0] WAKE_LEN_NONE   = 3'h7;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       we;
    logic       re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } swk_reg_req_t;

  typedef struct packed {
    logic                              valid;  // One pulse per scan period
    logic [NSENS-1:0][DIFF_W-1:0]      diff;
    logic [NSENS-1:0][THR_W-1:0]       thr;
  } swk_scan_t;

  typedef enum logic {WS_EXPECT, WS_RELEASE} swk_wake_st_t;

endpackage

// >>> swk_slider.sv
// Slider touch weight, location, motion and wake sequence block
// How it works
// - Flag motion when location change between scans exceeds the motion threshold
// - Touch weight sums each sensor's difference above its threshold; others excluded
// - Zero touch weight reports the slider released
// - Touch weight above hysteresis reports the slider touched
// - Location is weighted centroid of sensor indices times scale over 32
// - Scale is high byte register over low byte register
// - Location is readable as high and low byte registers
// - Location clamps between zero and scale over 32 times sensors minus one
// - Too many samples below negative threshold starts offset compensation
// - Counts above averaging threshold hold the averaging filters
// - Length 0 wakes on any event; 1 to 6 need keys in order
// - Length 7 ignores sensors; only general input or host command wake
// - A key counts only after its event is followed by release
// - Other events between key event and its release are ignored
// - A wrong event restarts the sequence from key zero
// - Key codes: buttons 0-11, slider touch, move low, move high, reserved
// - Hysteresis code counts in steps of four
// - Motion code is a percentage of the location limit
`timescale 1ns/1ps
module swk_slider (
  input  wire logic                  clk_sys,
  input  wire logic                  nrst,
  input  wire swk_pkg::swk_reg_req_t reg_req,
  input  wire swk_pkg::swk_scan_t    scan,
  input  wire logic [11:0]           button_touch,
  input  wire logic                  doze,
  input  wire logic                  general_input_event,
  input  wire logic                  host_wake_cmd,
  output logic [7:0]                 reg_rdata,
  output logic                       slider_touched,
  output logic                       move_low,
  output logic                       move_high,
  output logic [15:0]                slider_location,
  output logic                       comp_start,
  output logic                       avg_hold,
  output logic                       wake_req
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    // Host parameters
    logic [7:0]  hyst;
    logic [15:0] scale;
    logic [7:0]  avg_thr;
    logic [7:0]  neg_thr;
    logic [7:0]  neg_max;
    logic [7:0]  move_thr;
    logic [2:0]  wake_len;
    logic [23:0] keys;
    // Scan stage
    logic [15:0] weight;
    logic [17:0] wsum;
    logic        stage_v;
    // Results
    logic [15:0] loc;
    logic        loc_valid;
    logic        touched;
    logic        move_lo;
    logic        move_hi;
    logic [8:0]  neg_cnt;
    logic        comp;
    logic        hold;
    // Read data
    logic [7:0]  rdata;
  } swk_sld_state_t;

  swk_sld_state_t s_reg;
  swk_sld_state_t s_next;

  // Wake checker events; a key code is its bit index
  logic [swk_pkg::NEV-1:0] wake_events;

  // Contribution of one sensor: its count above threshold, else nothing
  function automatic logic [15:0] sensor_weight(input logic [swk_pkg::DIFF_W-1:0] d,
                                                input logic [swk_pkg::THR_W-1:0]  t);
    logic signed [15:0] ds;
    logic signed [15:0] ts;
    // Widened so a negative count never wraps into a weight
    ds = 16'(signed'(d));
    ts = signed'({6'h00, t});

    if (ds > ts) begin
      sensor_weight = 16'(ds - ts);
    end else begin
      sensor_weight = 16'h0000;
    end
  endfunction

  // Code in steps of four, widened to compare with a signed difference
  function automatic logic signed [15:0] code_counts(input logic [7:0] c);
    code_counts = signed'({6'h00, c, 2'b00});
  endfunction

  assign reg_rdata       = s_reg.rdata;
  assign slider_touched  = s_reg.touched;
  assign move_low        = s_reg.move_lo;
  assign move_high       = s_reg.move_hi;
  assign slider_location = s_reg.loc;
  assign comp_start      = s_reg.comp;
  assign avg_hold        = s_reg.hold;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0]        w;
    logic [15:0]        psum;
    logic [17:0]        isum;
    logic               neg_any;
    logic               pos_any;
    logic signed [15:0] ds;
    logic [15:0]        lim;
    logic [33:0]        num;
    logic [20:0]        den;
    logic [33:0]        quo;
    logic [15:0]        loc_new;
    logic [15:0]        delta;
    logic [23:0]        mthr;
    logic [8:0]         cnt;
    logic [7:0]         stat;

    w       = 16'h0000;
    psum    = 16'h0000;
    isum    = 18'h00000;
    neg_any = 1'b0;
    pos_any = 1'b0;
    ds      = 16'sh0000;
    cnt     = 9'h000;
    stat    = 8'h00;

    // Limit and motion threshold follow the live scale and motion codes
    lim     = 16'(32'(s_reg.scale >> swk_pkg::SCALE_SHIFT) * (swk_pkg::NSENS - 1));
    num     = 34'(s_reg.wsum) * 34'(s_reg.scale);
    den     = 21'(s_reg.weight) << swk_pkg::SCALE_SHIFT;
    // Truncating; the clamp covers scales that are not multiples of 32
    quo     = (den != 21'h0) ? num / 34'(den) : 34'h0;
    loc_new = (quo > 34'(lim)) ? lim : quo[15:0];
    delta   = (loc_new > s_reg.loc) ? loc_new - s_reg.loc : s_reg.loc - loc_new;
    mthr    = 24'((32'(lim) * 32'(s_reg.move_thr)) / swk_pkg::PERCENT_FULL);

    // Status byte and slider wake events come from the result registers; button events come straight from button_touch
    stat[swk_pkg::STAT_TOUCH_BIT] = s_reg.touched;
    stat[swk_pkg::STAT_LOW_BIT]   = s_reg.move_lo;
    stat[swk_pkg::STAT_HIGH_BIT]  = s_reg.move_hi;
    stat[swk_pkg::STAT_HOLD_BIT]  = s_reg.hold;
    wake_events = {3'b000, button_touch};
    wake_events[swk_pkg::EV_SLIDER_TOUCH] = s_reg.touched;
    wake_events[swk_pkg::EV_MOVE_LOW]     = s_reg.move_lo;
    wake_events[swk_pkg::EV_MOVE_HIGH]    = s_reg.move_hi;

    s_next         = s_reg;
    s_next.stage_v = 1'b0;
    s_next.comp    = 1'b0;
    s_next.move_lo = 1'b0;
    s_next.move_hi = 1'b0;

    // --------------------------------------------------------------
    // Register port
    // --------------------------------------------------------------
    if (reg_req.we) begin
      case (reg_req.addr)
        swk_pkg::ADDR_HYST:     s_next.hyst          = reg_req.wdata;
        swk_pkg::ADDR_SCALE_HI: s_next.scale[15:8]   = reg_req.wdata;
        swk_pkg::ADDR_SCALE_LO: s_next.scale[7:0]    = reg_req.wdata;
        swk_pkg::ADDR_AVG_THR:  s_next.avg_thr       = reg_req.wdata;
        swk_pkg::ADDR_NEG_THR:  s_next.neg_thr       = reg_req.wdata;
        swk_pkg::ADDR_NEG_CNT:  s_next.neg_max       = reg_req.wdata;
        swk_pkg::ADDR_MOVE_THR: s_next.move_thr      = reg_req.wdata;
        // Only three length bits are kept
        swk_pkg::ADDR_WAKE_LEN: s_next.wake_len      = reg_req.wdata[2:0];
        swk_pkg::ADDR_KEYS_54:  s_next.keys[23:16]   = reg_req.wdata;
        swk_pkg::ADDR_KEYS_32:  s_next.keys[15:8]    = reg_req.wdata;
        swk_pkg::ADDR_KEYS_10:  s_next.keys[7:0]     = reg_req.wdata;
        default: begin
          // Unmapped and read-only addresses ignore writes
        end
      endcase
    end

    // Host reads: data stands from the cycle after the strobe
    if (reg_req.re) begin
      case (reg_req.addr)
        swk_pkg::ADDR_HYST:     s_next.rdata = s_reg.hyst;
        swk_pkg::ADDR_STATUS:   s_next.rdata = stat;
        swk_pkg::ADDR_SCALE_HI: s_next.rdata = s_reg.scale[15:8];
        swk_pkg::ADDR_SCALE_LO: s_next.rdata = s_reg.scale[7:0];
        swk_pkg::ADDR_AVG_THR:  s_next.rdata = s_reg.avg_thr;
        swk_pkg::ADDR_NEG_THR:  s_next.rdata = s_reg.neg_thr;
        swk_pkg::ADDR_NEG_CNT:  s_next.rdata = s_reg.neg_max;
        swk_pkg::ADDR_MOVE_THR: s_next.rdata = s_reg.move_thr;
        // Bytes are not latched as a pair; read them between scans
        swk_pkg::ADDR_LOC_HI:   s_next.rdata = s_reg.loc[15:8];
        swk_pkg::ADDR_LOC_LO:   s_next.rdata = s_reg.loc[7:0];
        swk_pkg::ADDR_WAKE_LEN: s_next.rdata = {5'h00, s_reg.wake_len};
        swk_pkg::ADDR_KEYS_54:  s_next.rdata = s_reg.keys[23:16];
        swk_pkg::ADDR_KEYS_32:  s_next.rdata = s_reg.keys[15:8];
        swk_pkg::ADDR_KEYS_10:  s_next.rdata = s_reg.keys[7:0];
        // Unmapped reads return zero
        default:                s_next.rdata = 8'h00;
      endcase
    end

    // --------------------------------------------------------------
    // Scan stage: weights, compensation and averaging triggers
    // --------------------------------------------------------------
    if (scan.valid) begin
      for (int i = 0; i < swk_pkg::NSENS; i++) begin
        w    = sensor_weight(scan.diff[i], scan.thr[i]);
        psum = psum + w;
        isum = isum + 18'(w * 16'(i));
        // Thresholds are codes in steps of four counts
        ds   = 16'(signed'(scan.diff[i]));
        if (ds < -code_counts(s_reg.neg_thr)) begin
          neg_any = 1'b1;
        end
        if (ds > code_counts(s_reg.avg_thr)) begin
          pos_any = 1'b1;
        end
      end

      s_next.weight  = psum;
      s_next.wsum    = isum;
      s_next.stage_v = 1'b1;
      s_next.hold    = pos_any;

      // Strictly more than the limit: limit 1 fires on the second low scan
      if (neg_any) begin
        cnt = s_reg.neg_cnt + 9'h001;
        if (cnt > {1'b0, s_reg.neg_max}) begin
          s_next.comp    = 1'b1;
          s_next.neg_cnt = 9'h000;
        end else begin
          s_next.neg_cnt = cnt;
        end
      end else begin
        s_next.neg_cnt = 9'h000;
      end
    end

    // --------------------------------------------------------------
    // Result stage: status, location and motion, one cycle later
    // --------------------------------------------------------------
    if (s_reg.stage_v) begin
      if (s_reg.weight == 16'h0000) begin
        // Location is kept; the next touch skips the motion check
        s_next.touched   = 1'b0;
        s_next.loc_valid = 1'b0;
      end else begin
        // Between zero and hysteresis the status is left alone
        if (18'(s_reg.weight) > (18'(s_reg.hyst) << swk_pkg::CODE_STEP_SHIFT)) begin
          s_next.touched = 1'b1;
        end
        s_next.loc       = loc_new;
        s_next.loc_valid = 1'b1;

        // No motion is judged on the first sample of a touch
        if (s_reg.loc_valid && (24'(delta) > mthr)) begin
          s_next.move_hi = loc_new > s_reg.loc;
          s_next.move_lo = loc_new < s_reg.loc;
        end
      end
    end
  end

  // Parameters reset to their defaults, the rest to zero
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_reg          <= '0;
      s_reg.hyst     <= swk_pkg::RST_HYST;
      s_reg.scale    <= swk_pkg::RST_SCALE;
      s_reg.avg_thr  <= swk_pkg::RST_AVG_THR;
      s_reg.neg_thr  <= swk_pkg::RST_NEG_THR;
      s_reg.neg_max  <= swk_pkg::RST_NEG_CNT;
      s_reg.move_thr <= swk_pkg::RST_MOVE_THR;
      s_reg.wake_len <= swk_pkg::RST_WAKE_LEN;
      s_reg.keys     <= swk_pkg::RST_KEYS;
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Wake sequence
  // ----------------------------------------------------------------
  // Motion events last one cycle, so they also release on the next cycle
  // Doze and wake inputs share this clock, so no synchroniser
  swk_wake_seq u_wake (
    .clk_sys             (clk_sys),
    .nrst                (nrst),
    .doze                (doze),
    .seq_len             (s_reg.wake_len),
    .keys                (s_reg.keys),
    .sense               (wake_events),
    .general_input_event (general_input_event),
    .host_wake_cmd       (host_wake_cmd),
    .wake_req            (wake_req)
  );

endmodule // swk_slider

// >>> swk_slider_props.sv
// Concurrent checks on the slider and wake block ports
`timescale 1ns/1ps
module swk_slider_props (
  input wire logic                  clk_sys,
  input wire logic                  nrst,
  input wire swk_pkg::swk_reg_req_t reg_req,
  input wire swk_pkg::swk_scan_t    scan,
  input wire logic                  doze,
  input wire logic                  general_input_event,
  input wire logic [7:0]            reg_rdata,
  input wire logic                  slider_touched,
  input wire logic                  move_low,
  input wire logic                  move_high,
  input wire logic [15:0]           slider_location,
  input wire logic                  comp_start,
  input wire logic                  avg_hold,
  input wire logic                  wake_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  logic p_zero;
  logic any_neg;
  // ----------------------------------------------------------------
  // Scan helpers: zero weight when no sensor rises above its threshold
  // ----------------------------------------------------------------
  always_comb begin
    p_zero  = 1'b1;
    any_neg = 1'b0;
    for (int i = 0; i < swk_pkg::NSENS; i++) begin
      if ($signed(scan.diff[i]) > $signed({2'b00, scan.thr[i]})) p_zero = 1'b0;
      any_neg = any_neg | scan.diff[i][swk_pkg::DIFF_W-1];
    end
  end

  a_move_exclusive: assert property (!(move_low && move_high))
    else $error("both motion pulses high");
  a_move_from_scan: assert property ((move_low || move_high) |-> $past(scan.valid, 2))
    else $error("motion pulse without a scan");
  a_move_single: assert property (move_high |=> !move_high)
    else $error("motion pulse longer than one cycle");
  a_touch_on_scan: assert property ($changed(slider_touched) |-> $past(scan.valid, 2))
    else $error("touch status changed between scans");
  a_loc_on_scan: assert property ($changed(slider_location) |-> $past(scan.valid, 2))
    else $error("location changed between scans");
  a_zero_release: assert property (scan.valid && p_zero |=> ##1 !slider_touched)
    else $error("zero weight left slider touched");
  a_hold_on_scan: assert property ($changed(avg_hold) |-> $past(scan.valid))
    else $error("averaging hold changed between scans");
  a_comp_cause: assert property (comp_start |-> $past(scan.valid && any_neg))
    else $error("compensation start without a low sample");
  a_wake_in_doze: assert property (wake_req |-> $past(doze))
    else $error("wake request outside doze");
  a_input_wakes: assert property (doze && general_input_event |=> wake_req)
    else $error("general input did not wake");
  a_loc_low_read: assert property (reg_req.re && reg_req.addr == swk_pkg::ADDR_LOC_LO
    |=> reg_rdata == $past(slider_location[7:0]))
    else $error("location low byte read wrong");

  c_move_high: cover property (move_high);
  c_move_low: cover property (move_low);
  c_comp: cover property (comp_start);
  c_wake: cover property (wake_req);
endmodule // swk_slider_props

bind swk_slider swk_slider_props u_props (
  .clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req), .scan(scan), .doze(doze),
  .general_input_event(general_input_event), .reg_rdata(reg_rdata),
  .slider_touched(slider_touched), .move_low(move_low), .move_high(move_high),
  .slider_location(slider_location), .comp_start(comp_start), .avg_hold(avg_hold),
  .wake_req(wake_req));

// >>> swk_wake_seq.sv
// Doze-to-active wake sequence checker
`timescale 1ns/1ps
module swk_wake_seq (
  input  wire logic                         clk_sys,
  input  wire logic                         nrst,
  input  wire logic                         doze,
  input  wire logic [2:0]                   seq_len,
  input  wire logic [4*swk_pkg::NKEY-1:0]   keys,
  input  wire logic [swk_pkg::NEV-1:0]      sense,
  input  wire logic                         general_input_event,
  input  wire logic                         host_wake_cmd,
  output logic                              wake_req
);

  typedef struct packed {
    swk_pkg::swk_wake_st_t      st;
    logic [2:0]                 idx;
    logic [swk_pkg::NEV-1:0]    prev;
    logic                       wake;
  } swk_ws_state_t;

  swk_ws_state_t s_reg;
  swk_ws_state_t s_next;

  assign wake_req = s_reg.wake;

  always_comb begin
    logic [swk_pkg::NEV-1:0] rise;
    logic [3:0]              key;
    logic                    key_ok;
    rise   = sense & ~s_reg.prev;
    key    = keys[4*s_reg.idx +: 4];
    key_ok = (key < 4'(swk_pkg::NEV)) && rise[key];
    s_next      = s_reg;
    s_next.prev = sense;
    s_next.wake = 1'b0;
    if (!doze) begin
      s_next.st  = swk_pkg::WS_EXPECT;
      s_next.idx = 3'h0;
    end else if (general_input_event || host_wake_cmd) begin
      s_next.wake = 1'b1;
      s_next.st   = swk_pkg::WS_EXPECT;
      s_next.idx  = 3'h0;
    end else if (seq_len == swk_pkg::WAKE_LEN_NONE) begin
      s_next.st = swk_pkg::WS_EXPECT;
    end else if (seq_len == swk_pkg::WAKE_LEN_ANY) begin
      s_next.wake = |rise;
    end else begin
      case (s_reg.st)
        swk_pkg::WS_EXPECT: begin
          if (key_ok) begin
            s_next.st = swk_pkg::WS_RELEASE;
          end else if (|rise) begin
            s_next.idx = 3'h0;
          end
        end
        swk_pkg::WS_RELEASE: begin
          // Other events are ignored until the matched key lets go
          if (!sense[key]) begin
            s_next.st = swk_pkg::WS_EXPECT;
            if (s_reg.idx + 3'h1 == seq_len) begin
              s_next.wake = 1'b1;
              s_next.idx  = 3'h0;
            end else begin
              s_next.idx = s_reg.idx + 3'h1;
            end
          end
        end
        default: begin
          s_next.st  = swk_pkg::WS_EXPECT;
          s_next.idx = 3'h0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_reg <= '{st: swk_pkg::WS_EXPECT, idx: 3'h0, prev: '0, wake: 1'b0};
    end else begin
      s_reg <= s_next;
    end
  end

endmodule // swk_wake_seq

// >>> tb.sv
// Self-checking testbench for the slider and wake block
`timescale 1ns/1ps
module tb;
  logic                  clk_sys = 1'b0;
  logic                  nrst = 1'b0;
  swk_pkg::swk_reg_req_t reg_req;
  swk_pkg::swk_scan_t    scan = '0;
  logic [11:0]           button_touch = 12'h000;
  logic                  doze = 1'b0;
  logic                  gen_in = 1'b0;
  logic                  host_cmd = 1'b0;
  logic [7:0]            reg_rdata;
  logic                  slider_touched, move_low, move_high, comp_start, avg_hold, wake_req;
  logic [15:0]           slider_location;
  logic                  clr = 1'b0;
  logic [3:0]            f = 4'h0;
  logic [7:0]            d;
  int                    err_total = 0;
  int                    comparisons = 0;

  always #20 clk_sys = ~clk_sys;

  swk_host_model u_host (.clk_sys(clk_sys), .rdata(reg_rdata), .req(reg_req));
  swk_slider u_dut (
    .clk_sys(clk_sys), .nrst(nrst), .reg_req(reg_req), .scan(scan),
    .button_touch(button_touch), .doze(doze), .general_input_event(gen_in),
    .host_wake_cmd(host_cmd), .reg_rdata(reg_rdata), .slider_touched(slider_touched),
    .move_low(move_low), .move_high(move_high), .slider_location(slider_location),
    .comp_start(comp_start), .avg_hold(avg_hold), .wake_req(wake_req));

  // Sticky capture of one-cycle pulses: {move_high, move_low, comp_start, wake_req}
  always @(posedge clk_sys) f <= clr ? 4'h0 : f | {move_high, move_low, comp_start, wake_req};

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic clr_f;
    @(posedge clk_sys) clr <= 1'b1;
    @(posedge clk_sys) clr <= 1'b0;
  endtask

  // Sensors i and j get v, all others o; thresholds fixed at 100
  task automatic sc(input int i, input int j, input logic [11:0] v, input logic [11:0] o);
    logic [5:0][11:0] dv;
    for (int k = 0; k < 6; k++) dv[k] = (k == i || k == j) ? v : o;
    @(posedge clk_sys) begin
      scan <= '{valid: 1'b1, diff: dv, thr: {6{10'h064}}};
      clr  <= 1'b1;
    end
    @(posedge clk_sys) begin
      scan.valid <= 1'b0;
      clr        <= 1'b0;
    end
    repeat (6) @(posedge clk_sys);
    #1;
  endtask

  // Button k driven to the given level, then three cycles of waiting
  task automatic btn(input int k, input logic lvl);
    @(posedge clk_sys) button_touch[k] <= lvl;
    repeat (3) @(posedge clk_sys);
  endtask

  localparam logic [7:0] RA[11] = '{8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d, 8'h2e, 8'h2f,
                                    8'h30, 8'h33, 8'h36, 8'h40};
  localparam logic [7:0] RV[11] = '{8'h03, 8'h00, 8'h01, 8'h80, 8'h50, 8'h50, 8'h01,
                                    8'h02, 8'h00, 8'h00, 8'h00};

  initial begin
    repeat (20000) @(posedge clk_sys);
    err_total++;
    tally_and_finish;
  end

  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    for (int k = 0; k < 11; k++) begin
      u_host.rd(RA[k], d);
      chk(d, RV[k]);
    end
    u_host.wr(8'h33, 8'hff);
    u_host.rd(8'h33, d);
    chk(d, 8'h07);
    // Location, touch weight, motion direction
    sc(1, 1, 12'h0c8, 12'h000);
    chk({slider_touched, slider_location, f}, {1'b1, 16'd12, 4'h0});
    sc(4, 5, 12'h0c8, 12'h000);
    chk({slider_location, f}, {16'd54, 4'h8});
    u_host.rd(8'h31, d);
    chk(d, 8'h00);
    u_host.rd(8'h32, d);
    chk(d, 8'h36);
    sc(0, 0, 12'h0c8, 12'h000);
    chk({slider_location, f}, {16'd0, 4'h4});
    u_host.rd(8'h2a, d);
    chk(d, 8'h01);
    sc(2, 2, 12'h069, 12'h000);
    chk({slider_touched, slider_location}, {1'b1, 16'd24});
    sc(0, 0, 12'h000, 12'h000);
    chk({slider_touched, slider_location}, {1'b0, 16'd24});
    sc(2, 2, 12'h069, 12'h000);
    chk({slider_touched, f}, {1'b0, 4'h0});
    u_host.wr(8'h29, 8'h00);
    sc(2, 2, 12'h065, 12'h000);
    chk(slider_touched, 1'b1);
    // Scale 0x21f: 16 per sensor after truncation, limit 80, sensor 5 clamps
    u_host.wr(8'h2b, 8'h02);
    u_host.wr(8'h2c, 8'h1f);
    sc(2, 2, 12'h0c8, 12'h000);
    chk(slider_location, 16'd33);
    sc(5, 5, 12'h0c8, 12'h000);
    chk(slider_location, 16'd80);
    // Averaging hold just above and at the 320 threshold
    sc(0, 0, 12'h141, 12'h000);
    chk(avg_hold, 1'b1);
    sc(0, 0, 12'h140, 12'h000);
    chk({avg_hold, f}, {1'b0, 4'h0});
    // Compensation after the second consecutive low sample
    sc(0, 0, 12'hebf, 12'hebf);
    chk(f, 4'h0);
    sc(0, 0, 12'hebf, 12'hebf);
    chk(f, 4'h2);
    // Wake sequences in doze
    @(posedge clk_sys) doze <= 1'b1;
    u_host.wr(8'h33, 8'h00);
    clr_f;
    btn(7, 1'b1);
    btn(7, 1'b0);
    chk(f, 4'h1);
    u_host.wr(8'h33, 8'h02);
    u_host.wr(8'h36, 8'h53);
    clr_f;
    btn(3, 1'b1);
    btn(7, 1'b1);
    btn(7, 1'b0);
    btn(3, 1'b0);
    chk(f, 4'h0);
    btn(5, 1'b1);
    btn(5, 1'b0);
    chk(f, 4'h1);
    clr_f;
    btn(3, 1'b1);
    btn(3, 1'b0);
    btn(9, 1'b1);
    btn(9, 1'b0);
    btn(5, 1'b1);
    btn(5, 1'b0);
    chk(f, 4'h0);
    u_host.wr(8'h33, 8'h01);
    u_host.wr(8'h36, 8'h0c);
    sc(1, 1, 12'h0c8, 12'h000);
    sc(0, 0, 12'h000, 12'h000);
    chk(f[0], 1'b1);
    u_host.wr(8'h33, 8'h07);
    clr_f;
    btn(3, 1'b1);
    btn(3, 1'b0);
    chk(f, 4'h0);
    @(posedge clk_sys) gen_in <= 1'b1;
    @(posedge clk_sys) gen_in <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(f, 4'h1);
    clr_f;
    @(posedge clk_sys) host_cmd <= 1'b1;
    @(posedge clk_sys) host_cmd <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(f, 4'h1);
    @(posedge clk_sys) doze <= 1'b0;
    clr_f;
    @(posedge clk_sys) gen_in <= 1'b1;
    @(posedge clk_sys) gen_in <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(f, 4'h0);
    tally_and_finish;
  end
endmodule // tb
